//--- rfs_core_model.sv
// Behavioural model of the core that issues register file requests
`timescale 1ns/1ps
`default_nettype none
module rfs_core_model (
  input  wire logic           mclk,     // System clock
  output var logic            op_valid, // Request strobe
  output var rfs_pkg::rfs_op_t   op_kind,  // Operation kind
  output var rfs_pkg::rfs_mode_t op_mode,  // Addressing mode
  output var logic [7:0]      op_addr,  // Address or number
  output var logic [7:0]      op_data,  // Data or literal
  output var logic [15:0]     op_pc,    // PC to save
  output var logic [7:0]      op_flags  // Flags to save
);
  initial begin
    op_valid = 1'b0;
    op_kind  = rfs_pkg::op_read;
    op_mode  = rfs_pkg::register_mode;
    op_addr  = 8'h00;
    op_data  = 8'h00;
    op_pc    = 16'h0000;
    op_flags = 8'h00;
  end

  // One request, held through the taking edge; address, data, PC and flags scrambled after
  // Working area only by number or pointer, except refusal cases
  task automatic req(input rfs_pkg::rfs_op_t k,
                     input rfs_pkg::rfs_mode_t m,
                     input logic [7:0] a, input logic [7:0] d,
                     input logic [15:0] pc, input logic [7:0] fl);
    @(negedge mclk);
    op_valid = 1'b1;
    op_kind  = k;
    op_mode  = m;
    op_addr  = a;
    op_data  = d;
    op_pc    = pc;
    op_flags = fl;
    @(posedge mclk);
    @(negedge mclk);
    op_valid = 1'b0;
    op_addr  = ~op_addr;
    op_data  = ~op_data;
    op_pc    = ~op_pc;
    op_flags = ~op_flags;
  endtask : req
endmodule : rfs_core_model
`default_nettype wire

//--- rfs_pkg.sv
// Shared constants and types for the register file and stack
package rfs_pkg;
  localparam int          DATA_W      = 8;
  localparam int          PAIR_W      = 16;
  localparam int          TOTAL_REGS  = 240;
  localparam int          CTRL_REGS   = 32;
  localparam int          MEM_DEPTH   = TOTAL_REGS - CTRL_REGS;
  localparam logic [7:0]  GP_LAST     = 8'hBF;
  localparam logic [7:0]  WR_BASE     = 8'hC0;
  localparam logic [7:0]  WR_LAST     = 8'hCF;
  localparam logic [7:0]  ADDR_LAST   = 8'hEF;
  localparam logic [7:0]  SP_ADDR     = 8'hD9;
  localparam logic [7:0]  UNMAPPED_RD = 8'h00;
  localparam logic [7:0]  PAIR_MASK   = 8'hFE;
  localparam logic [7:0]  PAIR_LO     = 8'h01;
  localparam logic [7:0]  SP_STEP     = 8'h01;
  localparam logic [1:0]  CALL_BYTES  = 2'h2;
  localparam logic [1:0]  INT_BYTES   = 2'h3;

  typedef enum logic [2:0] {
    register_mode,
    working_mode,
    pointer_register_mode,
    indexed_mode,
    absolute_address_mode,
    pc_displacement_mode,
    literal_operand_mode
  } rfs_mode_t;

  typedef enum logic [3:0] {
    op_read,
    op_write,
    op_read_pair,
    op_push,
    op_pop,
    op_call,
    subroutine_return_op,
    op_interrupt,
    interrupt_return_op
  } rfs_op_t;
endpackage : rfs_pkg

//--- rfs_regfile.sv
// Register file with working area, pairs and in-file system stack
`timescale 1ns/1ps
`default_nettype none
module rfs_regfile (
  input  wire logic             mclk,       // System clock
  input  wire logic             nrst,       // Async reset, active low
  input  wire logic             op_valid,   // Operation request
  input  wire rfs_pkg::rfs_op_t op_kind,    // Operation kind
  input  wire rfs_pkg::rfs_mode_t op_mode,  // Operand addressing mode
  input  wire logic [7:0]       op_addr,    // Register address or number
  input  wire logic [7:0]       op_data,    // Write data or literal
  input  wire logic [15:0]      op_pc,      // PC to save
  input  wire logic [7:0]       op_flags,   // Flags to save
  output logic                  op_busy,    // Frame in progress
  output logic                  rd_valid,   // Read result valid
  output logic [7:0]            rd_data,    // Byte operand
  output logic [15:0]           rd_pair,    // Pair operand or pointer
  output logic                  mode_err,   // Refused addressing
  output logic                  ret_valid,  // Popped frame valid
  output logic [15:0]           ret_pc,     // Restored PC
  output logic [7:0]            ret_flags   // Restored flags
);
  rfs_stk_if stk ();

  rfs_stack_seq u_seq (
    .mclk (mclk),
    .nrst (nrst),
    .stk  (stk)
  );

  // Flat page-0 array; no page register exists to extend it
  logic [7:0] mem_q [0:rfs_pkg::MEM_DEPTH-1];
  logic [7:0] mem_d [0:rfs_pkg::MEM_DEPTH-1];
  logic [7:0] sp_q, sp_d;
  logic       rv_q, rv_d, err_q, err_d;
  logic [7:0] rd_q, rd_d;
  logic [15:0] pair_q, pair_d;

  logic       take, bad, wr_en;
  logic [7:0] loc, operand, wr_a, wr_v, top_byte, pair_hi, pair_lo;
  logic [7:0] work_byte;

  function automatic logic is_gp(input logic [7:0] a);
    return a <= rfs_pkg::WR_LAST;
  endfunction : is_gp

  function automatic logic is_work(input logic [7:0] a);
    return a >= rfs_pkg::WR_BASE && a <= rfs_pkg::WR_LAST;
  endfunction : is_work

  // Control bytes other than the stack pointer belong to peripherals
  function automatic logic [7:0] rd_loc(input logic [7:0] a);
    if (is_gp(a)) return mem_q[a];
    else if (a == rfs_pkg::SP_ADDR) return sp_q;
    else return rfs_pkg::UNMAPPED_RD;
  endfunction : rd_loc

  // Operand address resolution
  always_comb begin
    loc = op_addr;
    bad = 1'b0;
    case (op_mode)
      rfs_pkg::register_mode: begin
        loc = op_addr;
        bad = is_work(op_addr) || (op_addr > rfs_pkg::ADDR_LAST);
      end
      rfs_pkg::working_mode:
        loc = {rfs_pkg::WR_BASE[7:4], op_addr[3:0]};
      rfs_pkg::pointer_register_mode:
        loc = rd_loc(op_addr);
      rfs_pkg::literal_operand_mode: begin
        loc = op_addr;
        bad = (op_kind != rfs_pkg::op_read) && (op_kind != rfs_pkg::op_push);
      end
      default: bad = 1'b1;  // Other modes are refused here and flagged on mode_err
    endcase
    operand = (op_mode == rfs_pkg::literal_operand_mode) ? op_data
                                                         : rd_loc(loc);
    pair_hi = rd_loc(loc & rfs_pkg::PAIR_MASK);
    pair_lo = rd_loc((loc & rfs_pkg::PAIR_MASK) | rfs_pkg::PAIR_LO);
    top_byte = rd_loc(sp_q);
    work_byte = mem_q[{rfs_pkg::WR_BASE[7:4], op_addr[3:0]}];
    take = op_valid && !stk.busy && !bad;
  end

  // Request decode and stack frame hand-off
  always_comb begin
    stk.start = take && (op_kind == rfs_pkg::op_call ||
                         op_kind == rfs_pkg::subroutine_return_op ||
                         op_kind == rfs_pkg::op_interrupt ||
                         op_kind == rfs_pkg::interrupt_return_op);
    stk.kind  = op_kind;
    stk.pc    = op_pc;
    stk.flags = op_flags;
    stk.pop_byte = top_byte;
  end

  // Stack pointer and write port
  always_comb begin
    sp_d  = sp_q;
    wr_en = 1'b0;
    wr_a  = loc;
    wr_v  = op_data;
    rv_d  = 1'b0;
    rd_d  = rd_q;
    pair_d = pair_q;
    err_d = op_valid && !stk.busy && bad;
    if (stk.push) begin
      sp_d = sp_q - rfs_pkg::SP_STEP;
      wr_en = 1'b1; wr_a = sp_d; wr_v = stk.push_byte;
    end else if (stk.pop) begin
      sp_d = sp_q + rfs_pkg::SP_STEP;
    end else if (take) begin
      case (op_kind)
        rfs_pkg::op_read: begin
          rv_d = 1'b1; rd_d = operand;
        end
        rfs_pkg::op_read_pair: begin
          rv_d = 1'b1; pair_d = {pair_hi, pair_lo};
        end
        rfs_pkg::op_write: begin
          wr_en = 1'b1;
        end
        rfs_pkg::op_push: begin
          // Caller keeps the pointer in 01H-C0H before any push
          sp_d = sp_q - rfs_pkg::SP_STEP;
          wr_en = 1'b1; wr_a = sp_d; wr_v = operand;
        end
        rfs_pkg::op_pop: begin
          sp_d = sp_q + rfs_pkg::SP_STEP;
          wr_en = 1'b1; wr_v = top_byte;
          rv_d = 1'b1; rd_d = top_byte;
        end
        default: rv_d = 1'b0;
      endcase
    end
    // Writing D9H loads the pointer; a pop into D9H keeps the data
    if (wr_en && wr_a == rfs_pkg::SP_ADDR)
      sp_d = wr_v;
  end

  always_comb begin
    mem_d = mem_q;
    if (wr_en && is_gp(wr_a))
      mem_d[wr_a] = wr_v;
  end

  // Storage and pointer carry no reset: contents start undefined
  always_ff @(posedge mclk) begin
    mem_q <= mem_d;
    sp_q  <= sp_d;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rv_q <= 1'b0; err_q <= 1'b0; rd_q <= 8'h00; pair_q <= 16'h0000;
      op_busy <= 1'b0; ret_valid <= 1'b0; ret_pc <= 16'h0000;
      ret_flags <= 8'h00;
    end else begin
      rv_q <= rv_d; err_q <= err_d; rd_q <= rd_d; pair_q <= pair_d;
      op_busy <= stk.busy || stk.start;
      ret_valid <= stk.ret_valid;
      ret_pc <= stk.ret_pc;
      ret_flags <= stk.ret_flags;
    end
  end

  assign rd_valid = rv_q;
  assign rd_data  = rd_q;
  assign rd_pair  = pair_q;
  assign mode_err = err_q;

  push_dec_a: assert property (@(posedge mclk) disable iff (!nrst)
    (take && op_kind == rfs_pkg::op_push)
    |=> sp_q == $past(sp_q) - rfs_pkg::SP_STEP)
    else $error("push did not decrement pointer first");
  push_top_a: assert property (@(posedge mclk) disable iff (!nrst)
    (take && op_kind == rfs_pkg::op_push && sp_q <= rfs_pkg::WR_BASE
     && sp_q != 8'h00)
    |=> top_byte == $past(operand))
    else $error("pointer not at newest stacked byte");
  pop_inc_a: assert property (@(posedge mclk) disable iff (!nrst)
    (take && op_kind == rfs_pkg::op_pop && loc != rfs_pkg::SP_ADDR)
    |=> rd_data == $past(top_byte)
        && sp_q == $past(sp_q) + rfs_pkg::SP_STEP)
    else $error("pop did not read then increment");
  old_read_a: assert property (@(posedge mclk) disable iff (!nrst)
    (take && op_kind == rfs_pkg::op_read)
    |=> rd_valid && rd_data == $past(operand))
    else $error("read did not return pre-edge value");
  work_map_a: assert property (@(posedge mclk) disable iff (!nrst)
    (take && op_kind == rfs_pkg::op_read
     && op_mode == rfs_pkg::working_mode)
    |=> rd_data == $past(work_byte))
    else $error("working number not mapped into C0H-CFH");
  direct_err_a: assert property (@(posedge mclk) disable iff (!nrst)
    (op_valid && !stk.busy && op_mode == rfs_pkg::register_mode
     && is_work(op_addr))
    |=> mode_err && !rd_valid)
    else $error("direct access to working area not refused");
  pair_order_a: assert property (@(posedge mclk) disable iff (!nrst)
    (take && op_kind == rfs_pkg::op_read_pair)
    |=> rd_pair == {$past(pair_hi), $past(pair_lo)})
    else $error("pair byte order wrong");
  ctrl_dec_a: assert property (@(posedge mclk) disable iff (!nrst)
    (take && op_kind == rfs_pkg::op_read && op_mode == rfs_pkg::register_mode
     && op_addr > rfs_pkg::WR_LAST && op_addr != rfs_pkg::SP_ADDR)
    |=> rd_data == rfs_pkg::UNMAPPED_RD)
    else $error("control range read as storage");
  ret_pc_a: assert property (@(posedge mclk) disable iff (!nrst)
    (take && op_kind == rfs_pkg::subroutine_return_op)
    |-> ##4 ret_valid)
    else $error("return did not restore PC in time");

  // Refusal and result strobes, writes, pointer and frame steps: each check tied to its cause
  err_pulse_a: assert property (@(posedge mclk) disable iff (!nrst)
    (op_valid && !stk.busy && bad)
    |=> mode_err)
    else $error("refused mode gave no error pulse");
  no_err_a: assert property (@(posedge mclk) disable iff (!nrst)
    !(op_valid && !stk.busy && bad)
    |=> !mode_err)
    else $error("error pulse without refusal");
  rv_set_a: assert property (@(posedge mclk) disable iff (!nrst)
    (take && (op_kind == rfs_pkg::op_read || op_kind == rfs_pkg::op_pop
     || op_kind == rfs_pkg::op_read_pair))
    |=> rd_valid)
    else $error("result strobe missing");
  rv_quiet_a: assert property (@(posedge mclk) disable iff (!nrst)
    !(take && (op_kind == rfs_pkg::op_read || op_kind == rfs_pkg::op_pop
      || op_kind == rfs_pkg::op_read_pair))
    |=> !rd_valid)
    else $error("result strobe without read");
  wr_land_a: assert property (@(posedge mclk) disable iff (!nrst)
    (take && op_kind == rfs_pkg::op_write && op_addr <= rfs_pkg::GP_LAST
     && op_mode == rfs_pkg::register_mode)
    |=> mem_q[$past(op_addr)] == $past(op_data))
    else $error("write did not land at the edge");
  sp_load_a: assert property (@(posedge mclk) disable iff (!nrst)
    (take && op_kind == rfs_pkg::op_write && op_addr == rfs_pkg::SP_ADDR
     && op_mode == rfs_pkg::register_mode)
    |=> sp_q == $past(op_data))
    else $error("pointer not loaded by write");
  seq_dec_a: assert property (@(posedge mclk) disable iff (!nrst)
    stk.push
    |=> sp_q == $past(sp_q) - rfs_pkg::SP_STEP)
    else $error("frame push did not decrement pointer");
  seq_inc_a: assert property (@(posedge mclk) disable iff (!nrst)
    stk.pop
    |=> sp_q == $past(sp_q) + rfs_pkg::SP_STEP)
    else $error("frame pop did not increment pointer");
  seq_wr_a: assert property (@(posedge mclk) disable iff (!nrst)
    stk.push
    |=> top_byte == $past(stk.push_byte))
    else $error("frame byte not at new top");
  busy_out_a: assert property (@(posedge mclk) disable iff (!nrst)
    stk.start
    |=> op_busy)
    else $error("frame start not shown as busy");
  ret_pops_a: assert property (@(posedge mclk) disable iff (!nrst)
    (take && op_kind == rfs_pkg::subroutine_return_op)
    |=> stk.pop [*2] ##1 !stk.busy)
    else $error("return not two pops");
  lit_err_a: assert property (@(posedge mclk) disable iff (!nrst)
    (op_valid && !stk.busy && op_kind == rfs_pkg::op_write
     && op_mode == rfs_pkg::literal_operand_mode)
    |=> mode_err)
    else $error("literal write not refused");
  far_err_a: assert property (@(posedge mclk) disable iff (!nrst)
    (op_valid && !stk.busy && op_addr > rfs_pkg::ADDR_LAST
     && op_mode == rfs_pkg::register_mode)
    |=> mode_err && !rd_valid)
    else $error("address beyond file not refused");
  ext_err_a: assert property (@(posedge mclk) disable iff (!nrst)
    (op_valid && !stk.busy && (op_mode == rfs_pkg::indexed_mode
     || op_mode == rfs_pkg::absolute_address_mode
     || op_mode == rfs_pkg::pc_displacement_mode))
    |=> mode_err)
    else $error("outside mode not refused");
  start_one_a: assert property (@(posedge mclk) disable iff (!nrst)
    stk.start
    |=> !stk.start)
    else $error("second frame started while busy");
  pop_wr_a: assert property (@(posedge mclk) disable iff (!nrst)
    (take && op_kind == rfs_pkg::op_pop && op_addr <= rfs_pkg::GP_LAST
     && op_mode == rfs_pkg::register_mode)
    |=> mem_q[$past(op_addr)] == $past(top_byte))
    else $error("pop did not store top byte");
  pair_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    (take && op_kind == rfs_pkg::op_read)
    |=> rd_pair == $past(rd_pair))
    else $error("byte read disturbed pair result");
endmodule : rfs_regfile
`default_nettype wire

//--- rfs_stack_seq.sv
// Sequencer for call, return and interrupt stack frames
`timescale 1ns/1ps
`default_nettype none
module rfs_stack_seq (
  input  wire logic mclk,   // System clock
  input  wire logic nrst,   // Async reset, active low
  rfs_stk_if.seq    stk     // Link to register file
);
  typedef enum logic [1:0] {st_idle, st_push, st_pop} rfs_seq_st_t;

  rfs_seq_st_t st_q, st_d;
  logic [1:0]  left_q, left_d;
  logic [23:0] buf_q, buf_d;
  logic        interrupt_return_op_q, interrupt_return_op_d;
  logic        rv_q, rv_d;
  logic [15:0] rpc_q, rpc_d;
  logic [7:0]  rfl_q, rfl_d;
  logic [23:0] acc;

  always_comb begin
    st_d = st_q; left_d = left_q; buf_d = buf_q; interrupt_return_op_d = interrupt_return_op_q;
    rv_d = 1'b0; rpc_d = rpc_q; rfl_d = rfl_q;
    acc = {buf_q[15:0], stk.pop_byte};
    case (st_q)
      st_idle: begin
        if (stk.start) begin
          case (stk.kind)
            // Low byte first, so the high byte ends nearer the top
            rfs_pkg::op_call: begin
              st_d = st_push; left_d = rfs_pkg::CALL_BYTES;
              buf_d = {8'h00, stk.pc[15:8], stk.pc[7:0]};
            end
            rfs_pkg::op_interrupt: begin
              st_d = st_push; left_d = rfs_pkg::INT_BYTES;
              buf_d = {stk.flags, stk.pc[15:8], stk.pc[7:0]};
            end
            rfs_pkg::subroutine_return_op: begin
              st_d = st_pop; left_d = rfs_pkg::CALL_BYTES;
              interrupt_return_op_d = 1'b0; buf_d = 24'h000000;
            end
            rfs_pkg::interrupt_return_op: begin
              st_d = st_pop; left_d = rfs_pkg::INT_BYTES;
              interrupt_return_op_d = 1'b1; buf_d = 24'h000000;
            end
            default: st_d = st_idle;
          endcase
        end
      end
      st_push: begin
        buf_d = {8'h00, buf_q[23:8]};
        left_d = left_q - 2'h1;
        if (left_q == 2'h1) st_d = st_idle;
      end
      st_pop: begin
        buf_d = acc;
        left_d = left_q - 2'h1;
        if (left_q == 2'h1) begin
          st_d = st_idle; rv_d = 1'b1; rpc_d = acc[15:0];
          if (interrupt_return_op_q) rfl_d = acc[23:16];
        end
      end
      default: st_d = st_idle;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q <= st_idle; left_q <= 2'h0; buf_q <= 24'h000000;
      interrupt_return_op_q <= 1'b0; rv_q <= 1'b0; rpc_q <= 16'h0000;
      rfl_q <= 8'h00;
    end else begin
      st_q <= st_d; left_q <= left_d; buf_q <= buf_d;
      interrupt_return_op_q <= interrupt_return_op_d; rv_q <= rv_d; rpc_q <= rpc_d;
      rfl_q <= rfl_d;
    end
  end

  assign stk.busy      = (st_q != st_idle);
  assign stk.push      = (st_q == st_push);
  assign stk.pop       = (st_q == st_pop);
  assign stk.push_byte = buf_q[7:0];
  assign stk.ret_valid = rv_q;
  assign stk.ret_pc    = rpc_q;
  assign stk.ret_flags = rfl_q;

  call_frame_a: assert property (@(posedge mclk) disable iff (!nrst)
    (stk.start && !stk.busy && stk.kind == rfs_pkg::op_call)
    |=> stk.push [*2] ##1 !stk.busy)
    else $error("call frame not two pushes");
  int_frame_a: assert property (@(posedge mclk) disable iff (!nrst)
    (stk.start && !stk.busy && stk.kind == rfs_pkg::op_interrupt)
    |=> stk.push [*3] ##1 !stk.busy)
    else $error("interrupt frame not three pushes");
  interrupt_return_op_done_a: assert property (@(posedge mclk) disable iff (!nrst)
    (stk.start && !stk.busy && stk.kind == rfs_pkg::interrupt_return_op)
    |=> stk.pop [*3] ##1 (stk.ret_valid && !stk.busy))
    else $error("interrupt return not done in three pops");
endmodule : rfs_stack_seq
`default_nettype wire

//--- rfs_stk_if.sv
// Carrier between register file and multi-byte stack sequencer
`timescale 1ns/1ps
`default_nettype none
interface rfs_stk_if;
  logic                  start;
  rfs_pkg::rfs_op_t      kind;
  logic [15:0]           pc;
  logic [7:0]            flags;
  logic                  busy;
  logic                  push;
  logic                  pop;
  logic [7:0]            push_byte;
  logic [7:0]            pop_byte;
  logic                  ret_valid;
  logic [15:0]           ret_pc;
  logic [7:0]            ret_flags;

  modport seq (input start, kind, pc, flags, pop_byte,
               output busy, push, pop, push_byte,
               ret_valid, ret_pc, ret_flags);
  modport mem (output start, kind, pc, flags, pop_byte,
               input busy, push, pop, push_byte,
               ret_valid, ret_pc, ret_flags);
endinterface : rfs_stk_if
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the register file and stack
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic               mclk;
  logic               nrst;
  logic               op_valid;
  rfs_pkg::rfs_op_t   op_kind;
  rfs_pkg::rfs_mode_t op_mode;
  logic [7:0]         op_addr;
  logic [7:0]         op_data;
  logic [15:0]        op_pc;
  logic [7:0]         op_flags;
  logic               op_busy;
  logic               rd_valid;
  logic [7:0]         rd_data;
  logic [15:0]        rd_pair;
  logic               mode_err;
  logic               ret_valid;
  logic [15:0]        ret_pc;
  logic [7:0]         ret_flags;
  int                 fail_count;
  int                 checks;
  logic [7:0]         ga [5] = '{8'h00, 8'h10, 8'h11, 8'h7E, 8'hBF};
  rfs_pkg::rfs_mode_t bm [5] = '{rfs_pkg::register_mode,
    rfs_pkg::register_mode, rfs_pkg::indexed_mode,
    rfs_pkg::absolute_address_mode, rfs_pkg::pc_displacement_mode};
  logic [7:0]         ba [5] = '{8'hC3, 8'hF0, 8'h10, 8'h10, 8'h10};

  rfs_core_model rfs_core_model_inst (.mclk(mclk), .op_valid(op_valid),
    .op_kind(op_kind), .op_mode(op_mode), .op_addr(op_addr),
    .op_data(op_data), .op_pc(op_pc), .op_flags(op_flags));

  rfs_regfile rfs_regfile_inst (.mclk(mclk), .nrst(nrst),
    .op_valid(op_valid), .op_kind(op_kind), .op_mode(op_mode),
    .op_addr(op_addr), .op_data(op_data), .op_pc(op_pc),
    .op_flags(op_flags), .op_busy(op_busy), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_pair(rd_pair), .mode_err(mode_err),
    .ret_valid(ret_valid), .ret_pc(ret_pc), .ret_flags(ret_flags));

  task automatic give_verdict();
    if (fail_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask : chk

  task automatic rq(input rfs_pkg::rfs_op_t k,
                    input rfs_pkg::rfs_mode_t m,
                    input logic [7:0] a, input logic [7:0] d);
    rfs_core_model_inst.req(k, m, a, d, 16'h0000, 8'h00);
  endtask : rq

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    rq(rfs_pkg::op_write, rfs_pkg::register_mode, a, d);
  endtask : wr

  // Valid pulse and data checked in the one cycle they stand
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rq(rfs_pkg::op_read, rfs_pkg::register_mode, a, 8'h00);
    chk({7'h00, rd_valid, rd_data}, {8'h01, e});
  endtask : rd

  task automatic frame(input rfs_pkg::rfs_op_t k, input logic [15:0] pc,
                       input logic [7:0] fl, input int lat);
    int n;
    rfs_core_model_inst.req(k, rfs_pkg::register_mode, 8'h00, 8'h00,
                            pc, fl);
    n = 1;
    if (lat > 0) begin
      while (ret_valid !== 1'b1 && n < 20) begin
        @(negedge mclk);
        n++;
      end
      chk(16'(n), 16'(lat));
    end
    n = 0;
    while (op_busy !== 1'b0 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 20) begin
      fail_count++;
      give_verdict();
    end
    @(negedge mclk);
  endtask : frame

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  initial begin
    nrst       = 1'b0;
    fail_count = 0;
    checks     = 0;
    repeat (6) @(negedge mclk);
    nrst = 1'b1;
    @(negedge mclk);
    chk({rd_valid, mode_err, ret_valid, op_busy}, 16'h0000);
    // Stack pointer loaded before any stack use, top at BFH
    wr(rfs_pkg::SP_ADDR, 8'hC0);
    rd(8'hD9, 8'hC0);
    for (int i = 0; i < 5; i++) wr(ga[i], ga[i] ^ 8'h5A);
    for (int i = 0; i < 5; i++) rd(ga[i], ga[i] ^ 8'h5A);
    rq(rfs_pkg::op_read_pair, rfs_pkg::register_mode, 8'h11, 8'h00);
    chk(rd_pair, 16'h4A4B);
    rq(rfs_pkg::op_write, rfs_pkg::working_mode, 8'h02, 8'h77);
    wr(8'h40, 8'hC2);
    rq(rfs_pkg::op_read, rfs_pkg::pointer_register_mode,
       8'h40, 8'h00);
    chk({rd_valid, rd_data}, 16'h0177);
    rq(rfs_pkg::op_read, rfs_pkg::working_mode, 8'h02, 8'h00);
    chk({rd_valid, rd_data}, 16'h0177);
    for (int i = 0; i < 5; i++) begin
      rq(rfs_pkg::op_read, bm[i], ba[i], 8'h00);
      chk({mode_err, rd_valid}, 16'h0002);
    end
    rd(8'hD0, rfs_pkg::UNMAPPED_RD);
    rq(rfs_pkg::op_read, rfs_pkg::literal_operand_mode,
       8'h00, 8'h6D);
    chk({rd_valid, rd_data}, 16'h016D);
    rq(rfs_pkg::op_write, rfs_pkg::literal_operand_mode,
       8'h10, 8'h00);
    chk({mode_err, rd_valid}, 16'h0002);
    rd(8'h10, 8'h4A);
    rq(rfs_pkg::op_push, rfs_pkg::literal_operand_mode,
       8'h00, 8'h11);
    rq(rfs_pkg::op_push, rfs_pkg::register_mode, 8'h10, 8'h00);
    rd(8'hD9, 8'hBE);
    rd(8'hBF, 8'h11);
    rd(8'hBE, 8'h4A);
    rq(rfs_pkg::op_pop, rfs_pkg::register_mode, 8'h30, 8'h00);
    chk({rd_valid, rd_data}, 16'h014A);
    rd(8'h30, 8'h4A);
    rd(8'hD9, 8'hBF);
    frame(rfs_pkg::op_call, 16'h1234, 8'h00, 0);
    rd(8'hD9, 8'hBD);
    rd(8'hBD, 8'h12);
    rd(8'hBE, 8'h34);
    frame(rfs_pkg::subroutine_return_op, 16'h0000, 8'h00, 4);
    chk(ret_pc, 16'h1234);
    rd(8'hD9, 8'hBF);
    frame(rfs_pkg::op_interrupt, 16'h5678, 8'h9A, 0);
    rd(8'hD9, 8'hBC);
    rd(8'hBC, 8'h9A);
    rd(8'hBD, 8'h56);
    rd(8'hBE, 8'h78);
    frame(rfs_pkg::interrupt_return_op, 16'h0000, 8'h00, 5);
    chk(ret_pc, 16'h5678);
    chk({8'h00, ret_flags}, 16'h009A);
    rd(8'hD9, 8'hBF);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
